// *** uxd_fifo.sv ***
// parameterised fifo with registered head data and registered flags
`timescale 1ns/100ps
module uxd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         pclk,      // system clock
  input  wire logic         presetn,   // async reset, active low
  input  wire logic         in_valid,  // write request
  input  wire logic [W-1:0] in_data,   // write data
  output logic              in_ready,  // room for one word
  output logic              out_valid, // head word present
  output logic [W-1:0]      out_data,  // head word
  input  wire logic         out_ready, // consumer takes head
  output logic [AW:0]       level      // words stored
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_level;
  logic          push;
  logic          pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be a power of two of at least two");
    end
  end

  // handshakes and next occupancy
  always_comb begin
    push        = in_valid & in_ready;
    pop         = out_valid & out_ready;
    next_rd_ptr = rd_ptr + AW'(pop);
    next_level  = level + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // storage, no reset needed on the array
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and flags, flags registered so ports come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr    <= '0;
      wr_ptr    <= '0;
      level     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      rd_ptr    <= next_rd_ptr;
      wr_ptr    <= wr_ptr + AW'(push);
      level     <= next_level;
      in_ready  <= next_level != (AW + 1)'(DEPTH);
      out_valid <= next_level != '0;
    end
  end

  // head register, bypass when the new head is being written now
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data <= '0;
    end else if (push && wr_ptr == next_rd_ptr) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[next_rd_ptr];
    end
  end
endmodule : uxd_fifo

// *** uxd_pkg.sv ***
// shared constants for the uart receive dma termination block
package uxd_pkg;
  // apb geometry: printed offsets are word indices, byte address is index times four
  localparam int          ADDR_W        = 18;
  localparam int          IDX_W         = 16;
  localparam logic [15:0] IDX_RX_DATA   = 16'hFFA0; // uart_rx_fifo_data
  localparam logic [15:0] IDX_TX_HOLD   = 16'hFFA1; // uart_tx_hold_data
  localparam logic [15:0] IDX_CTRL      = 16'hFFE4; // rx_channel_control
  localparam logic [15:0] IDX_STATUS    = 16'hFFE5; // rx_channel_timeout_status
  localparam logic [15:0] IDX_INFO      = 16'hFFE6; // rx_channel_info

  // rx_channel_timeout_status fields
  localparam int          ST_OVERRUN    = 0;
  localparam int          ST_TIMEOUT    = 1;
  localparam int          ST_CNT_LO     = 2;
  localparam int          ST_CNT_HI     = 6;
  localparam int          ST_TEN        = 7;
  localparam logic [4:0]  TIMEOUT_RESET = 5'h00;

  // rx_channel_control fields
  localparam int          CT_IRQ_EN     = 6;
  localparam int          CT_EN         = 7;

  // rx_channel_info fields
  localparam int          IN_BCNT_LO    = 0;
  localparam int          IN_RXLVL_LO   = 8;
  localparam int          IN_DMALVL_LO  = 16;
  localparam int          IN_TXFULL     = 24;
  localparam int          IN_RXERR      = 25;

  // timing
  localparam int          CLK_HZ        = 25000000;
  localparam int          BAUD_DEFAULT  = 115200;
  localparam int          BIT_CNT_W     = 16;
  localparam int          DATA_BITS     = 8;
  localparam int          RX_DEPTH      = 32;
  localparam int          DMA_DEPTH     = 8;
endpackage : uxd_pkg

// *** uxd_rx_dma.sv ***
// uart receive dma channel with time-out counter, completion flags and data registers
`timescale 1ns/100ps
module uxd_rx_dma #(
  parameter int BAUD      = uxd_pkg::BAUD_DEFAULT,
  parameter int RX_DEPTH  = uxd_pkg::RX_DEPTH,
  parameter int DMA_DEPTH = uxd_pkg::DMA_DEPTH
) (
  input  wire logic                       pclk,              // 25 mhz clock
  input  wire logic                       presetn,           // async reset, active low
  input  wire logic                       psel,              // apb select
  input  wire logic                       penable,           // apb access phase
  input  wire logic                       pwrite,            // apb write
  input  wire logic [uxd_pkg::ADDR_W-1:0] paddr,             // apb byte address
  input  wire logic [31:0]                pwdata,            // apb write data
  output logic      [31:0]                prdata,            // apb read data
  output logic                            pready,            // apb ready
  output logic                            pslverr,           // apb error, unmapped
  input  wire logic                       serial_input_pin,  // uart receive line
  output logic                            serial_output_pin, // uart transmit line
  input  wire logic                       sof_pulse,         // 1 ms frame tick
  output logic      [7:0]                 dma_out_data,      // byte toward ram
  output logic                            dma_out_valid,     // byte toward ram valid
  input  wire logic                       dma_out_ready,     // ram side accepts
  input  wire logic [7:0]                 dma_tx_data,       // byte from ram
  input  wire logic                       dma_tx_valid,      // byte from ram valid
  output logic                            dma_tx_ready,      // tx hold empty
  output logic                            dma_irq            // one-cycle dma interrupt
);
  localparam int CYC_BIT  = uxd_pkg::CLK_HZ / BAUD;
  localparam int CYC_HALF = CYC_BIT / 2;
  localparam int RXA      = $clog2(RX_DEPTH);
  localparam int DMAA     = $clog2(DMA_DEPTH);
  localparam logic [uxd_pkg::BIT_CNT_W-1:0] BIT_LAST  = uxd_pkg::BIT_CNT_W'(CYC_BIT - 1);
  localparam logic [uxd_pkg::BIT_CNT_W-1:0] HALF_LAST = uxd_pkg::BIT_CNT_W'(CYC_HALF - 1);
  localparam logic [3:0] DATA_LAST = 4'(uxd_pkg::DATA_BITS - 1);
  localparam logic [3:0] FRAME_LAST = 4'(uxd_pkg::DATA_BITS + 1);

  initial begin
    if (CYC_BIT < 4 || CYC_BIT >= (1 << uxd_pkg::BIT_CNT_W)) begin
      $error("baud rate out of range for the bit counter");
    end
    if (RX_DEPTH < 2 || DMA_DEPTH < 2 || RX_DEPTH > 64 || DMA_DEPTH > 128) begin
      $error("fifo depths unsupported by the info register");
    end
  end

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } uxd_rx_state_t;

  // register state
  logic                 timeout_count_enable;
  logic [4:0]           tmo_value;
  logic                 timeout_flag;
  logic                 overrun_flag;
  logic                 chan_en;
  logic                 dma_irq_enable_bit;
  logic [7:0]           byte_count;
  logic                 rx_err_seen;
  logic [4:0]           tmo_cnt;
  logic                 got_byte;

  // apb decode
  logic [uxd_pkg::IDX_W-1:0] idx;
  logic                 setup;
  logic                 acc_wr;
  logic                 acc_rd;
  logic                 hit;
  logic                 wr_status;
  logic                 wr_ctrl;

  // receiver
  logic                 rx_s1;
  logic                 rx_s2;
  uxd_rx_state_t        rx_state;
  logic [uxd_pkg::BIT_CNT_W-1:0] rx_cnt;
  logic [3:0]           rx_bit;
  logic [7:0]           rx_shift;
  logic                 rx_done;
  logic                 rx_err;

  // fifo links
  logic                 rxf_in_ready;
  logic                 rxf_out_valid;
  logic [7:0]           rxf_out_data;
  logic                 rxf_pop;
  logic [RXA:0]         rxf_level;
  logic                 dmaf_in_ready;
  logic [DMAA:0]        dmaf_level;
  logic                 dma_move;
  logic                 apb_rx_pop;

  // termination
  logic                 run;
  logic                 timeout_evt;
  logic                 overrun_evt;
  logic                 err_halt;
  logic                 next_en;

  // transmitter
  logic                 hold_full;
  logic [7:0]           hold_data;
  logic                 next_hold_full;
  logic                 tx_busy;
  logic [9:0]           tx_shift;
  logic [3:0]           tx_bit;
  logic [uxd_pkg::BIT_CNT_W-1:0] tx_cnt;
  logic                 tx_load;

  // address and phase decode; the low two address bits are ignored
  always_comb begin
    idx       = paddr[uxd_pkg::ADDR_W-1:2];
    setup     = psel & ~penable;
    acc_wr    = psel & penable & pwrite;
    acc_rd    = psel & penable & ~pwrite;
    hit       = idx == uxd_pkg::IDX_RX_DATA || idx == uxd_pkg::IDX_TX_HOLD ||
                idx == uxd_pkg::IDX_CTRL || idx == uxd_pkg::IDX_STATUS ||
                idx == uxd_pkg::IDX_INFO;
    wr_status = acc_wr && idx == uxd_pkg::IDX_STATUS;
    wr_ctrl   = acc_wr && idx == uxd_pkg::IDX_CTRL;
  end

  // read data and error captured in setup, so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= ~hit;
        prdata  <= 32'h0000_0000;
        unique case (1'b1)
          idx == uxd_pkg::IDX_RX_DATA: begin
            prdata[7:0] <= rxf_out_valid ? rxf_out_data : 8'h00;
          end
          idx == uxd_pkg::IDX_STATUS: begin
            prdata[uxd_pkg::ST_TEN]                       <= timeout_count_enable;
            prdata[uxd_pkg::ST_CNT_HI:uxd_pkg::ST_CNT_LO] <= tmo_value;
            prdata[uxd_pkg::ST_TIMEOUT]                   <= timeout_flag;
            prdata[uxd_pkg::ST_OVERRUN]                   <= overrun_flag;
          end
          idx == uxd_pkg::IDX_CTRL: begin
            prdata[uxd_pkg::CT_EN]     <= chan_en;
            prdata[uxd_pkg::CT_IRQ_EN] <= dma_irq_enable_bit;
          end
          idx == uxd_pkg::IDX_INFO: begin
            prdata[uxd_pkg::IN_BCNT_LO +: 8]         <= byte_count;
            prdata[uxd_pkg::IN_RXLVL_LO +: RXA + 1]  <= rxf_level;
            prdata[uxd_pkg::IN_DMALVL_LO +: DMAA + 1] <= dmaf_level;
            prdata[uxd_pkg::IN_TXFULL]               <= hold_full;
            prdata[uxd_pkg::IN_RXERR]                <= rx_err_seen;
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // input line synchroniser, second stage is the only reader of the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= serial_input_pin;
      rx_s2 <= rx_s1;
    end
  end

  // 8n1 receiver, samples mid-bit; a low stop bit is a framing error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= 4'h0;
      rx_shift <= 8'h00;
      rx_done  <= 1'b0;
      rx_err   <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_err  <= 1'b0;
      unique case (rx_state)
        RX_IDLE: begin
          rx_cnt <= '0;
          if (!rx_s2) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == HALF_LAST) begin
            rx_cnt   <= '0;
            rx_bit   <= 4'h0;
            rx_state <= rx_s2 ? RX_IDLE : RX_DATA; // glitch rejects
          end
        end
        RX_DATA: begin
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == BIT_LAST) begin
            rx_cnt   <= '0;
            rx_shift <= {rx_s2, rx_shift[7:1]};
            rx_bit   <= rx_bit + 1'b1;
            if (rx_bit == DATA_LAST) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == BIT_LAST) begin
            rx_done  <= rx_s2;
            rx_err   <= ~rx_s2;
            rx_state <= RX_IDLE;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // dma path: rx fifo head to the ram-side buffer while the channel runs
  always_comb begin
    dma_move   = chan_en & rxf_out_valid & dmaf_in_ready;
    apb_rx_pop = acc_rd && idx == uxd_pkg::IDX_RX_DATA && !chan_en &&
                 rxf_out_valid;
    rxf_pop    = dma_move | apb_rx_pop;
  end

  uxd_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_done),
    .in_data   (rx_shift),
    .in_ready  (rxf_in_ready),
    .out_valid (rxf_out_valid),
    .out_data  (rxf_out_data),
    .out_ready (rxf_pop),
    .level     (rxf_level)
  );

  uxd_fifo #(.W(8), .DEPTH(DMA_DEPTH)) u_dma_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (dma_move),
    .in_data   (rxf_out_data),
    .in_ready  (dmaf_in_ready),
    .out_valid (dma_out_valid),
    .out_data  (dma_out_data),
    .out_ready (dma_out_ready),
    .level     (dmaf_level)
  );

  // termination causes and next channel enable
  always_comb begin
    run         = timeout_count_enable & chan_en & got_byte;
    timeout_evt = run && tmo_cnt == 5'h00 && !dma_move;
    overrun_evt = chan_en & rx_done & ~rxf_in_ready & ~dmaf_in_ready;
    err_halt    = chan_en & rx_err;
    next_en     = chan_en;
    if (wr_ctrl) begin
      next_en = pwdata[uxd_pkg::CT_EN];
    end else if (err_halt) begin
      next_en = 1'b0;
    end else if ((timeout_evt || overrun_evt) && dma_irq_enable_bit) begin
      next_en = 1'b0;
    end
  end

  // channel control and the interrupt on a falling enable, none when a framing error halts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_en            <= 1'b0;
      dma_irq_enable_bit <= 1'b0;
      dma_irq            <= 1'b0;
    end else begin
      chan_en <= next_en;
      if (wr_ctrl) begin
        dma_irq_enable_bit <= pwdata[uxd_pkg::CT_IRQ_EN];
      end
      dma_irq <= chan_en & ~next_en & dma_irq_enable_bit & ~err_halt;
    end
  end

  // time-out field and enable, plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_count_enable       <= 1'b0;
      tmo_value <= uxd_pkg::TIMEOUT_RESET;
    end else if (wr_status) begin
      timeout_count_enable       <= pwdata[uxd_pkg::ST_TEN];
      tmo_value <= pwdata[uxd_pkg::ST_CNT_HI:uxd_pkg::ST_CNT_LO];
    end
  end

  // completion flags: hardware set beats a simultaneous write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      timeout_flag <= timeout_evt | overrun_evt |
                      (timeout_flag & ~(wr_status & pwdata[uxd_pkg::ST_TIMEOUT]));
      overrun_flag <= overrun_evt |
                      (overrun_flag & ~(wr_status & pwdata[uxd_pkg::ST_OVERRUN]));
    end
  end

  // down counter: reload per byte, step per frame tick, stop after halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt  <= 5'h00;
      got_byte <= 1'b0;
    end else if (timeout_evt || overrun_evt || err_halt || !chan_en) begin
      got_byte <= 1'b0;
    end else if (dma_move) begin
      tmo_cnt  <= tmo_value;
      got_byte <= 1'b1;
    end else if (run && sof_pulse) begin
      tmo_cnt  <= tmo_cnt - 5'h01;
    end
  end

  // bytes moved since the channel was started; frozen while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_count  <= 8'h00;
      rx_err_seen <= 1'b0;
    end else begin
      if (!chan_en && next_en) begin
        byte_count <= 8'h00;
      end else if (dma_move) begin
        byte_count <= byte_count + 8'h01;
      end
      if (!chan_en && next_en) begin
        rx_err_seen <= 1'b0;
      end else if (rx_err) begin
        rx_err_seen <= 1'b1;
      end
    end
  end

  // tx hold: a processor write wins over the dma in the same cycle
  always_comb begin
    tx_load        = ~tx_busy & hold_full;
    next_hold_full = hold_full & ~tx_load;
    if (acc_wr && idx == uxd_pkg::IDX_TX_HOLD && !next_hold_full) begin
      next_hold_full = 1'b1;
    end else if (dma_tx_valid && dma_tx_ready && !next_hold_full) begin
      next_hold_full = 1'b1;
    end
  end

  // hold register and its ready, one word behind the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_full    <= 1'b0;
      hold_data    <= 8'h00;
      dma_tx_ready <= 1'b0;
    end else begin
      hold_full    <= next_hold_full;
      dma_tx_ready <= ~next_hold_full;
      if (acc_wr && idx == uxd_pkg::IDX_TX_HOLD && (!hold_full || tx_load)) begin
        hold_data <= pwdata[7:0];
      end else if (dma_tx_valid && dma_tx_ready && (!hold_full || tx_load)) begin
        hold_data <= dma_tx_data;
      end
    end
  end

  // 8n1 shifter, line idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy           <= 1'b0;
      tx_shift          <= 10'h3FF;
      tx_bit            <= 4'h0;
      tx_cnt            <= '0;
      serial_output_pin <= 1'b1;
    end else if (tx_load) begin
      tx_busy           <= 1'b1;
      tx_shift          <= {1'b1, hold_data, 1'b0};
      tx_bit            <= 4'h0;
      tx_cnt            <= '0;
    end else if (tx_busy) begin
      serial_output_pin <= tx_shift[0];
      tx_cnt            <= tx_cnt + 1'b1;
      if (tx_cnt == BIT_LAST) begin
        tx_cnt   <= '0;
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bit   <= tx_bit + 1'b1;
        tx_busy  <= tx_bit != FRAME_LAST;
      end
    end else begin
      serial_output_pin <= 1'b1;
    end
  end
endmodule : uxd_rx_dma

// *** uxd_rx_dma_properties.sv ***
// port checks for the uart receive dma block
`timescale 1ns/100ps
module uxd_rx_dma_properties (
  input wire logic        pclk,              // clock
  input wire logic        presetn,           // reset, low
  input wire logic        psel,              // apb select
  input wire logic        penable,           // apb access
  input wire logic [31:0] prdata,            // read data
  input wire logic        pready,            // apb ready
  input wire logic        pslverr,           // apb error
  input wire logic        serial_output_pin, // tx line
  input wire logic [7:0]  dma_out_data,      // byte to ram
  input wire logic        dma_out_valid,     // byte valid
  input wire logic        dma_out_ready,     // ram takes
  input wire logic        dma_tx_valid,      // byte from ram
  input wire logic        dma_tx_ready,      // hold empty
  input wire logic        dma_irq            // interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // four clocks is the shortest bit that any legal baud gives
  sequence s_start_bit;
    !serial_output_pin [*4];
  endsequence
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_read_hold: assert property (!(psel && !penable) |=>
    $stable(prdata) && $stable(pslverr))
    else $error("read data moved outside setup");
  a_err_zero: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_tx_take: assert property (dma_tx_valid && dma_tx_ready |=> !dma_tx_ready)
    else $error("hold still empty after take");
  // past pready keeps the release of reset out of this one
  a_tx_start: assert property ($rose(dma_tx_ready) && $past(pready) |=> s_start_bit)
    else $error("no start bit after load");
  a_start_width: assert property ($fell(serial_output_pin) |-> s_start_bit)
    else $error("start bit too short");
  a_out_hold: assert property (dma_out_valid && !dma_out_ready |=>
    dma_out_valid && $stable(dma_out_data))
    else $error("byte toward ram dropped");
  a_irq_pulse: assert property (dma_irq |=> !dma_irq)
    else $error("interrupt longer than a cycle");
endmodule : uxd_rx_dma_properties

bind uxd_rx_dma uxd_rx_dma_properties i_props (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .serial_output_pin, .dma_out_data, .dma_out_valid, .dma_out_ready,
  .dma_tx_valid, .dma_tx_ready, .dma_irq);

// *** uxd_rx_dma_test.sv ***
// self-checking bench for the uart receive dma block
`timescale 1ns/100ps
module uxd_rx_dma_test;
  localparam int BAUD = 6250000; // four clocks a bit keeps frames short
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sof_pulse = 0;
  logic        dma_tx_valid = 0, dma_out_ready = 0, stall = 0, e;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d, exp_info;
  logic        pready, pslverr, rx_line, tx_line, dma_out_valid, dma_tx_ready, dma_irq, got;
  logic [7:0]  dma_out_data, got_byte, b, dma_tx_data = 0, seed = 8'h11;
  logic [7:0]  rx_q[$], tx_q[$];
  int          fail_count = 0, comparisons = 0, irq_n = 0, cyc = 0;

  uxd_rx_dma #(.BAUD(BAUD)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_input_pin(rx_line),
    .serial_output_pin(tx_line), .sof_pulse, .dma_out_data, .dma_out_valid, .dma_out_ready,
    .dma_tx_data, .dma_tx_valid, .dma_tx_ready, .dma_irq);
  uxd_uart_peer #(.CYC(uxd_pkg::CLK_HZ / BAUD)) i_peer (.pclk, .tx_line, .rx_line,
    .got_byte, .got);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, g, x);
    end
  endtask : chk

  // apb master: holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] v);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= {i, 2'h0};
    pwdata  <= 32'(v);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1);
    d = prdata;
    e = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask : apb

  task automatic rdc(input logic [15:0] i, input logic [31:0] x);
    apb(0, i, 0);
    chk(d, x);
  endtask : rdc

  task automatic sof(input int n);
    repeat (n) begin
      @(posedge pclk) sof_pulse <= 1;
      @(posedge pclk) sof_pulse <= 0;
    end
  endtask : sof

  // note first: the byte may reach ram before the frame ends
  task automatic rxb(input logic note);
    b = seed;
    if (note)
      rx_q.push_back(b);
    i_peer.send(b, 1'h1);
  endtask : rxb

  task automatic push(input logic [7:0] v);
    tx_q.push_back(v);
    @(posedge pclk);
    dma_tx_valid <= 1;
    dma_tx_data  <= v;
    do @(posedge pclk); while (dma_tx_ready !== 1'h1);
    dma_tx_valid <= 0;
  endtask : push

  initial forever #20 pclk = ~pclk;

  // random ram-side stalls and the watchdog
  always @(posedge pclk) begin
    seed          <= lfsr(seed);
    dma_out_ready <= !stall && seed[0];
    cyc           <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // results appear here and meet the oldest note
  always @(posedge pclk) begin
    if (dma_out_valid === 1'h1 && dma_out_ready === 1'h1)
      chk(32'(dma_out_data), 32'(rx_q.pop_front()));
    if (got === 1'h1)
      chk(32'(got_byte), 32'(tx_q.pop_front()));
    if (dma_irq === 1'h1)
      irq_n++;
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rdc(uxd_pkg::IDX_STATUS, 0);
    rdc(uxd_pkg::IDX_TX_HOLD, 0);
    apb(0, 16'h0000, 0);
    chk(32'(e), 1);
    wr_ctl(8'h80);
    repeat (3) rxb(1);
    $display("test reset and stream done");
    // two ms limit, a second byte reloads it
    wr_ctl(8'h00);
    apb(1, uxd_pkg::IDX_STATUS, 8'h88);
    wr_ctl(8'h80);
    rxb(1);
    sof(1);
    rxb(1);
    sof(1);
    rdc(uxd_pkg::IDX_STATUS, 8'h88);
    sof(1);
    rdc(uxd_pkg::IDX_STATUS, 8'h8A);
    rdc(uxd_pkg::IDX_CTRL, 8'h80);
    apb(1, uxd_pkg::IDX_STATUS, 8'h88);
    rdc(uxd_pkg::IDX_STATUS, 8'h8A);
    apb(1, uxd_pkg::IDX_STATUS, 8'h8A);
    rdc(uxd_pkg::IDX_STATUS, 8'h88);
    apb(1, uxd_pkg::IDX_STATUS, 8'h08);
    rxb(1);
    sof(4);
    rdc(uxd_pkg::IDX_STATUS, 8'h08);
    $display("test timeout done");
    // restart with interrupt on; no byte yet, so no expiry
    wr_ctl(8'h00);
    wr_ctl(8'hC0);
    apb(1, uxd_pkg::IDX_STATUS, 8'h84);
    sof(2);
    rdc(uxd_pkg::IDX_STATUS, 8'h84);
    rxb(1);
    sof(1);
    rdc(uxd_pkg::IDX_STATUS, 8'h86);
    rdc(uxd_pkg::IDX_CTRL, 8'h40);
    // ram stalls until both buffers fill and one more byte lands
    apb(1, uxd_pkg::IDX_STATUS, 8'h02);
    wr_ctl(8'h80);
    wait (rx_q.size() == 0); // a byte left in the ram-side fifo would shift the overrun point
    stall <= 1;
    repeat (uxd_pkg::RX_DEPTH + uxd_pkg::DMA_DEPTH) rxb(1);
    rxb(0);
    rdc(uxd_pkg::IDX_STATUS, 8'h03);
    rdc(uxd_pkg::IDX_CTRL, 8'h80);
    // only the ram-side fifo's worth was moved, both fifos full
    exp_info = (uxd_pkg::DMA_DEPTH << uxd_pkg::IN_DMALVL_LO) | uxd_pkg::DMA_DEPTH |
               (uxd_pkg::RX_DEPTH << uxd_pkg::IN_RXLVL_LO);
    rdc(uxd_pkg::IDX_INFO, exp_info);
    apb(1, uxd_pkg::IDX_STATUS, 8'h03);
    stall <= 0;
    wait (rx_q.size() == 0);
    $display("test overrun done");
    // channel off: the processor pops the receive fifo itself
    wr_ctl(8'h00);
    rxb(0);
    rdc(uxd_pkg::IDX_RX_DATA, 32'(b));
    rdc(uxd_pkg::IDX_RX_DATA, 0);
    b = seed;
    tx_q.push_back(b);
    apb(1, uxd_pkg::IDX_TX_HOLD, b);
    push(~b);
    wait (tx_q.size() == 0);
    $display("test direct and transmit done");
    // stop bit low ends the channel without an interrupt
    stall <= 1;
    wr_ctl(8'hC0);
    i_peer.send(8'h55, 1'h0);
    rdc(uxd_pkg::IDX_CTRL, 8'h40);
    rdc(uxd_pkg::IDX_STATUS, 0);
    rdc(uxd_pkg::IDX_INFO, 32'h1 << uxd_pkg::IN_RXERR);
    chk(32'(irq_n), 1);
    $display("test framing done");
    report_and_stop();
  end

  task automatic wr_ctl(input logic [7:0] v);
    apb(1, uxd_pkg::IDX_CTRL, v);
  endtask : wr_ctl
endmodule : uxd_rx_dma_test

// *** uxd_uart_peer.sv ***
// serial partner: drives the receive line and decodes the transmit line
`timescale 1ns/100ps
module uxd_uart_peer #(
  parameter int CYC = 4
) (
  input  wire logic  pclk,     // clock
  input  wire logic  tx_line,  // line from block
  output logic       rx_line,  // line into block
  output logic [7:0] got_byte, // decoded byte
  output logic       got       // decode strobe
);
  // frame: start, data lsb first, stop, then one idle bit
  task automatic send(input logic [7:0] v, input logic stop);
    logic [10:0] f;
    f = {1'h1, stop, v, 1'h0};
    @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (CYC) @(posedge pclk);
    end
  endtask : send
  // decode samples mid-bit, so small phase drift is harmless
  initial begin
    rx_line = 1'h1;
    got     = 1'h0;
    forever begin
      @(negedge tx_line);
      repeat (CYC / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (CYC) @(posedge pclk);
        got_byte[i] = tx_line;
      end
      repeat (CYC) @(posedge pclk);
      got <= 1'h1;
      @(posedge pclk);
      got <= 1'h0;
    end
  end
endmodule : uxd_uart_peer
